// File: common/map_entry_pkg.sv
// constants, field layout and helpers shared by the address map entry ends
package map_entry_pkg;

  // entry word offsets on the configuration port
  localparam logic [3:0]  OFF_ATTR       = 4'h0;
  localparam logic [3:0]  OFF_START      = 4'h4;
  localparam logic [3:0]  OFF_END        = 4'h8;
  localparam logic [3:0]  OFF_HASH       = 4'hc;

  // attribute field positions
  localparam int          VALID_POS      = 0;
  localparam int          DEST_POS       = 1;
  localparam int          PORT_LSB       = 4;
  localparam int          PORT_W         = 4;
  localparam int          AGG_LSB        = 10;
  localparam int          AGG_W          = 4;

  // writable bits; everything else reads as zero
  localparam logic [31:0] ATTR_WR_MASK   = 32'h0000_3cf3;
  localparam logic [31:0] AGG_FIELD_MASK = 32'h0000_3c00;
  localparam logic [31:0] HASH_WR_MASK   = 32'hffff_ffc0;

  // reset values
  localparam logic [31:0] ATTR_RST       = 32'h0000_0000;
  localparam logic [31:0] BOUND_RST      = 32'h0000_0000;
  localparam logic [31:0] HASH_RST       = 32'h0000_0000;

  // controller registers on the AHB-Lite side
  localparam logic [4:0]  CTL_CMD        = 5'h00;
  localparam logic [4:0]  CTL_WDATA      = 5'h04;
  localparam logic [4:0]  CTL_RDATA      = 5'h08;
  localparam logic [4:0]  CTL_STATUS     = 5'h0c;
  localparam int          CMD_GO         = 0;
  localparam int          CMD_WRITE      = 1;
  localparam int          CMD_SEL_LSB    = 4;
  localparam int          CMD_FLR        = 8;
  localparam int          CMD_NORMAL     = 9;
  localparam int          ST_BUSY        = 0;
  localparam int          ST_REFUSED     = 1;
  localparam logic [31:0] CMD_RST        = 32'h0000_0000;

  // legal aggregation encodings: 0h, 1h, 3h, 7h, Fh
  function automatic logic agg_legal(input logic [AGG_W-1:0] cnt);
    agg_legal = ((cnt + 4'h1) & cnt) == 4'h0;
  endfunction : agg_legal

endpackage : map_entry_pkg

// File: common/map_cfg_if.sv
// configuration link between the map controller and the map entry
interface map_cfg_if;
  logic        cfg_req;    // one-cycle request
  logic        cfg_we;     // request is a write
  logic [3:0]  cfg_addr;   // entry byte offset
  logic [31:0] cfg_wdata;  // write data
  logic [31:0] cfg_rdata;  // read data, valid with ack
  logic        cfg_ack;    // one-cycle answer
  logic        func_reset; // one-cycle function-level reset

  modport device (
    input  cfg_req,
    input  cfg_we,
    input  cfg_addr,
    input  cfg_wdata,
    input  func_reset,
    output cfg_rdata,
    output cfg_ack
  );

  modport host (
    output cfg_req,
    output cfg_we,
    output cfg_addr,
    output cfg_wdata,
    output func_reset,
    input  cfg_rdata,
    input  cfg_ack
  );
endinterface : map_cfg_if

// File: core/map_port_hash.sv
// folds the masked address into a member index for an aggregated group
module map_port_hash #(
  parameter int ADDR_W = 32,
  parameter int IDX_W  = 4
) (
  input  wire logic [ADDR_W-1:0] addr_i,   // lookup address bits
  input  wire logic [ADDR_W-1:0] mask_i,   // hash select mask
  input  wire logic [IDX_W-1:0]  count_i,  // group size minus one
  output logic      [IDX_W-1:0]  member_o  // member index within group
);

  if (ADDR_W % IDX_W != 0) begin : g_chk
    $error("map_port_hash: ADDR_W must be a multiple of IDX_W");
  end

  wire [ADDR_W-1:0] masked = addr_i & mask_i;
  logic [IDX_W-1:0] fold;

  // xor of all index-wide slices; only selected bits take part
  always_comb begin
    fold = '0;
    for (int i = 0; i < ADDR_W / IDX_W; i++) begin
      fold = fold ^ masked[i*IDX_W +: IDX_W];
    end
  end

  // count is all ones below its top bit, so it trims to the group size
  assign member_o = fold & count_i;

endmodule : map_port_hash

// File: core/map_entry_device.sv
// one programmable address map entry with port aggregation routing
module map_entry_device
  import map_entry_pkg::*;
#(
  parameter bit ALIGN_4GB = 1'b0, // 1: bounds compare address bits 63:32
  parameter int LK_ADDR_W = 64    // lookup address width
) (
  input  wire logic                  clk_i,        // 25 MHz clock
  input  wire logic                  srst_i,       // sync reset, active high
  map_cfg_if.device                  cfg,          // configuration link
  input  wire logic                  lk_req_i,     // lookup request pulse
  input  wire logic [LK_ADDR_W-1:0]  lk_addr_i,    // lookup address
  output logic                       lk_done_o,    // lookup answer pulse
  output logic                       lk_hit_o,     // address in window
  output logic                       lk_to_port_o, // destination is a port
  output logic [map_entry_pkg::PORT_W-1:0] lk_port_o // routed port number
);
  import map_entry_pkg::*;

  if (LK_ADDR_W != 64) begin : g_chk
    $error("map_entry_device: LK_ADDR_W must be 64");
  end

  // ---------------------------------------------------------------
  // entry storage
  // ---------------------------------------------------------------
  logic [31:0] attr_r;
  logic [31:0] start_r;
  logic [31:0] end_r;
  logic [31:0] hash_r;
  logic [31:0] rdata_r;
  logic        ack_r;

  logic        done_r;
  logic        hit_r;
  logic        to_port_r;
  logic [PORT_W-1:0] port_r;

  // ---------------------------------------------------------------
  // configuration decode
  // ---------------------------------------------------------------
  wire wr_en    = cfg.cfg_req & cfg.cfg_we;
  wire wr_attr  = wr_en & (cfg.cfg_addr == OFF_ATTR);
  wire wr_start = wr_en & (cfg.cfg_addr == OFF_START);
  wire wr_end   = wr_en & (cfg.cfg_addr == OFF_END);
  wire wr_hash  = wr_en & (cfg.cfg_addr == OFF_HASH);

  // only the defined fields are stored, so reserved bits read zero
  wire [31:0] attr_wdata = cfg.cfg_wdata & ATTR_WR_MASK;
  wire [31:0] hash_wdata = cfg.cfg_wdata & HASH_WR_MASK;

  logic [31:0] rd_mux;
  always_comb begin
    case (cfg.cfg_addr)
      OFF_ATTR:  rd_mux = attr_r;
      OFF_START: rd_mux = start_r;
      OFF_END:   rd_mux = end_r;
      OFF_HASH:  rd_mux = hash_r;
      default:   rd_mux = 32'h0000_0000;
    endcase
  end

  // ---------------------------------------------------------------
  // attribute fields
  // ---------------------------------------------------------------
  wire              entry_valid   = attr_r[VALID_POS];
  wire              dest_is_port  = attr_r[DEST_POS];
  wire [PORT_W-1:0] target_port   = attr_r[PORT_LSB +: PORT_W];
  wire [AGG_W-1:0]  agg_field     = attr_r[AGG_LSB +: AGG_W];

  // the count means nothing for a local agent destination
  wire [AGG_W-1:0]  agg_count     = dest_is_port ? agg_field : '0;

  // ---------------------------------------------------------------
  // register writes
  // ---------------------------------------------------------------
  // function-level reset clears the entry but keeps the aggregation
  // count, so a group survives a function reset while the window does not
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      attr_r <= ATTR_RST;
    end else if (cfg.func_reset) begin
      attr_r <= attr_r & AGG_FIELD_MASK;
    end else if (wr_attr) begin
      attr_r <= attr_wdata;
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i || cfg.func_reset) begin
      start_r <= BOUND_RST;
      end_r   <= BOUND_RST;
      hash_r  <= HASH_RST;
    end else begin
      if (wr_start) begin
        start_r <= cfg.cfg_wdata;
      end
      if (wr_end) begin
        end_r <= cfg.cfg_wdata;
      end
      if (wr_hash) begin
        hash_r <= hash_wdata;
      end
    end
  end

  // every request is answered on the next edge, reads and writes alike
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      ack_r   <= 1'b0;
      rdata_r <= 32'h0000_0000;
    end else begin
      ack_r <= cfg.cfg_req;
      if (cfg.cfg_req && !cfg.cfg_we) begin
        rdata_r <= rd_mux;
      end
    end
  end

  assign cfg.cfg_ack   = ack_r;
  assign cfg.cfg_rdata = rdata_r;

  // ---------------------------------------------------------------
  // lookup
  // ---------------------------------------------------------------
  // in 4GB mode a bound names a 4GB block, else a plain 32-bit address
  wire [31:0] win_addr = ALIGN_4GB ? lk_addr_i[63:32] : lk_addr_i[31:0];

  // inclusive on both ends; alignment of the bounds is software's job
  wire in_window = entry_valid &
                   (win_addr >= start_r) &
                   (win_addr <= end_r);

  wire [PORT_W-1:0] member;

  map_port_hash #(
    .ADDR_W (32),
    .IDX_W  (PORT_W)
  ) u_hash (
    .addr_i   (lk_addr_i[31:0]),
    .mask_i   (hash_r),
    .count_i  (agg_count),
    .member_o (member)
  );

  // zero count leaves member at zero, giving the single target port;
  // otherwise the group counts upward from the first port, any base
  wire [PORT_W-1:0] route_port = target_port + member;

  // the port number wraps past the top port; software is expected to
  // keep first port plus count within range
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      done_r    <= 1'b0;
      hit_r     <= 1'b0;
      to_port_r <= 1'b0;
      port_r    <= '0;
    end else begin
      done_r <= lk_req_i;
      if (lk_req_i) begin
        hit_r     <= in_window;
        to_port_r <= in_window & dest_is_port;
        port_r    <= (in_window & dest_is_port) ? route_port : '0;
      end
    end
  end

  assign lk_done_o    = done_r;
  assign lk_hit_o     = hit_r;
  assign lk_to_port_o = to_port_r;
  assign lk_port_o    = port_r;

endmodule : map_entry_device

// File: core/map_entry_ctrl.sv
// AHB-Lite controller that programs the map entry over the config link
module map_entry_ctrl
  import map_entry_pkg::*;
(
  input  wire logic        clk_i,       // 25 MHz clock
  input  wire logic        srst_i,      // sync reset, active high
  input  wire logic        hsel_i,      // AHB slave select
  input  wire logic [31:0] haddr_i,     // AHB address
  input  wire logic [1:0]  htrans_i,    // AHB transfer type
  input  wire logic        hwrite_i,    // AHB write
  input  wire logic [2:0]  hsize_i,     // AHB size, word only
  input  wire logic [31:0] hwdata_i,    // AHB write data
  input  wire logic        hready_i,    // AHB bus ready
  output logic             hreadyout_o, // AHB slave ready
  output logic             hresp_o,     // AHB response, always okay
  output logic [31:0]      hrdata_o,    // AHB read data
  map_cfg_if.host          cfg          // configuration link
);
  import map_entry_pkg::*;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_REQ  = 3'b010,
    ST_WAIT = 3'b100
  } seq_e;

  seq_e        state_r;
  seq_e        state_nxt;
  logic [31:0] cmd_r;
  logic [31:0] wdata_r;
  logic [31:0] rdata_r;
  logic        refused_r;
  logic        flr_r;
  logic        ph_wr_r;
  logic [4:0]  ph_addr_r;
  logic [31:0] hrdata_r;

  // address phase is taken on a selected active transfer when the bus is ready; no wait states
  wire        addr_ph  = hsel_i & htrans_i[1] & hready_i;
  wire        wr_cmd   = ph_wr_r & (ph_addr_r == CTL_CMD);
  wire        wr_wdata = ph_wr_r & (ph_addr_r == CTL_WDATA);
  wire        idle     = (state_r == ST_IDLE);
  wire        go       = wr_cmd & hwdata_i[CMD_GO];
  wire [3:0]  sel      = hwdata_i[CMD_SEL_LSB +: 4];
  wire [AGG_W-1:0] new_agg = wdata_r[AGG_LSB +: AGG_W];

  // an attribute write is checked before it reaches the entry
  wire bad_agg   = ~agg_legal(new_agg);
  wire bad_local = (new_agg != '0) & ~wdata_r[DEST_POS];
  wire bad_mem   = (new_agg != '0) & ~hwdata_i[CMD_NORMAL];
  wire attr_wr   = hwdata_i[CMD_WRITE] & (sel == OFF_ATTR);
  wire illegal   = attr_wr & (bad_agg | bad_local | bad_mem);
  wire launch    = go & idle & ~illegal;
  // a command while busy is dropped and flagged like an illegal one
  wire refuse    = go & (~idle | illegal);

  wire [31:0] status = {30'h0, refused_r, ~idle};

  logic [31:0] rd_mux;
  always_comb begin
    case (haddr_i[4:0])
      CTL_CMD:    rd_mux = cmd_r;
      CTL_WDATA:  rd_mux = wdata_r;
      CTL_RDATA:  rd_mux = rdata_r;
      CTL_STATUS: rd_mux = status;
      default:    rd_mux = 32'h0000_0000;
    endcase
  end

  always_comb begin
    case (state_r)
      ST_IDLE: state_nxt = launch ? ST_REQ : ST_IDLE;
      ST_REQ:  state_nxt = ST_WAIT;
      ST_WAIT: state_nxt = cfg.cfg_ack ? ST_IDLE : ST_WAIT;
      default: state_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      ph_wr_r   <= 1'b0;
      ph_addr_r <= 5'h00;
      hrdata_r  <= 32'h0000_0000;
    end else begin
      ph_wr_r   <= addr_ph & hwrite_i;
      ph_addr_r <= haddr_i[4:0];
      if (addr_ph && !hwrite_i) begin
        hrdata_r <= rd_mux;
      end
    end
  end

  // a single entry cannot overlap another; software keeps ranges apart
  // when several entries share one map
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      state_r   <= ST_IDLE;
      cmd_r     <= CMD_RST;
      wdata_r   <= 32'h0000_0000;
      rdata_r   <= 32'h0000_0000;
      refused_r <= 1'b0;
      flr_r     <= 1'b0;
    end else begin
      state_r <= state_nxt;
      flr_r   <= wr_cmd & hwdata_i[CMD_FLR];
      if (wr_cmd && idle) begin
        cmd_r <= hwdata_i;
      end
      if (wr_wdata && idle) begin
        wdata_r <= hwdata_i;
      end
      if (state_r == ST_WAIT && cfg.cfg_ack && !cmd_r[CMD_WRITE]) begin
        rdata_r <= cfg.cfg_rdata;
      end
      // a new refusal wins over the clear of an accepted command
      if (refuse) begin
        refused_r <= 1'b1;
      end else if (launch) begin
        refused_r <= 1'b0;
      end
    end
  end

  assign hreadyout_o    = 1'b1;
  assign hresp_o        = 1'b0;
  assign hrdata_o       = hrdata_r;
  assign cfg.cfg_req    = (state_r == ST_REQ);
  assign cfg.cfg_we     = cmd_r[CMD_WRITE];
  assign cfg.cfg_addr   = cmd_r[CMD_SEL_LSB +: 4];
  assign cfg.cfg_wdata  = wdata_r;
  assign cfg.func_reset = flr_r;

endmodule : map_entry_ctrl

// File: tb/map_entry_chk.sv
// assertions on the configuration link between controller and entry
module map_entry_chk (
  input wire logic        clk_i,     // clock
  input wire logic        srst_i,    // sync reset
  input wire logic        cfg_req,   // request
  input wire logic        cfg_we,    // write
  input wire logic [3:0]  cfg_addr,  // entry offset
  input wire logic [31:0] cfg_wdata, // write data
  input wire logic [31:0] cfg_rdata, // read data
  input wire logic        cfg_ack,   // answer
  input wire logic        func_reset // function reset
);
  import map_entry_pkg::*;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);
  logic [31:0] attr_r;
  logic [31:0] start_r;
  logic [31:0] end_r;
  wire         aw_w  = cfg_req && cfg_we && cfg_addr == OFF_ATTR;
  wire  [3:0]  cnt_w = cfg_wdata[13:10];
  // shadow of what the entry should hold; function reset beats a write
  always_ff @(posedge clk_i) begin
    if (srst_i || func_reset) begin
      attr_r  <= srst_i ? '0 : attr_r & AGG_FIELD_MASK;
      start_r <= '0;
      end_r   <= '0;
    end else if (cfg_req && cfg_we) begin
      if (cfg_addr == OFF_ATTR) attr_r <= cfg_wdata & ATTR_WR_MASK;
      if (cfg_addr == OFF_START) start_r <= cfg_wdata;
      if (cfg_addr == OFF_END) end_r <= cfg_wdata;
    end
  end
  sequence s_rd(logic [3:0] off);
    cfg_req && !cfg_we && cfg_addr == off ##1 cfg_ack;
  endsequence
  property p_ack_after_req;
    cfg_req |=> cfg_ack;
  endproperty
  property p_ack_cause;
    cfg_ack |-> $past(cfg_req);
  endproperty
  property p_rdata_hold;
    cfg_req && cfg_we |=> $stable(cfg_rdata);
  endproperty
  property p_attr_rb;
    s_rd(OFF_ATTR) |-> cfg_rdata == $past(attr_r);
  endproperty
  property p_start_rb;
    s_rd(OFF_START) |-> cfg_rdata == $past(start_r);
  endproperty
  property p_end_rb;
    s_rd(OFF_END) |-> cfg_rdata == $past(end_r);
  endproperty
  property p_wr_legal;
    aw_w |-> cnt_w inside {4'h0, 4'h1, 4'h3, 4'h7, 4'hf};
  endproperty
  property p_agg_port;
    aw_w && cnt_w != 4'h0 |-> cfg_wdata[1];
  endproperty
  a_ack_after_req: assert property (p_ack_after_req)
    else $error("no answer after request");
  a_ack_cause: assert property (p_ack_cause)
    else $error("answer without request");
  a_rdata_hold: assert property (p_rdata_hold)
    else $error("read data moved on a write");
  a_attr_rb: assert property (p_attr_rb)
    else $error("attribute readback wrong");
  a_start_rb: assert property (p_start_rb)
    else $error("start bound readback wrong");
  a_end_rb: assert property (p_end_rb)
    else $error("end bound readback wrong");
  a_wr_legal: assert property (p_wr_legal)
    else $error("reserved count sent to entry");
  a_agg_port: assert property (p_agg_port)
    else $error("count sent for agent destination");
endmodule : map_entry_chk

// File: tb/tb.sv
// self-checking bench: controller and entry joined by the config link
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import map_entry_pkg::*;
  logic        clk_i  = 1'b0;
  logic        srst_i = 1'b1;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic        hsel   = 1'b0;
  logic [2:0]  hsize  = 3'h0;
  logic        lk_req = 1'b0;
  logic        rd_dp  = 1'b0;
  logic [31:0] haddr  = '0;
  logic [31:0] hwdata = '0;
  logic [63:0] lk_addr = '0;
  logic        hready, hresp, lk_done, lk_hit, lk_to_port;
  logic [31:0] hrdata, e_attr, e_st, e_end, e_hash;
  logic [3:0]  lk_port;
  logic [31:0] rq[$], rm[$];
  logic [5:0]  lq[$];
  int          failures = 0;
  int          comparisons = 0;
  map_cfg_if cfg ();
  map_entry_ctrl i_map_entry_ctrl (
    .clk_i(clk_i), .srst_i(srst_i), .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans),
    .hwrite_i(hwrite), .hsize_i(hsize), .hwdata_i(hwdata), .hready_i(hready),
    .hreadyout_o(hready), .hresp_o(hresp), .hrdata_o(hrdata), .cfg(cfg));
  map_entry_device #(.ALIGN_4GB(1'b0), .LK_ADDR_W(64)) i_map_entry_device (
    .clk_i(clk_i), .srst_i(srst_i), .cfg(cfg), .lk_req_i(lk_req), .lk_addr_i(lk_addr),
    .lk_done_o(lk_done), .lk_hit_o(lk_hit), .lk_to_port_o(lk_to_port), .lk_port_o(lk_port));
  map_entry_chk i_map_entry_chk (
    .clk_i(clk_i), .srst_i(srst_i), .cfg_req(cfg.cfg_req), .cfg_we(cfg.cfg_we),
    .cfg_addr(cfg.cfg_addr), .cfg_wdata(cfg.cfg_wdata), .cfg_rdata(cfg.cfg_rdata),
    .cfg_ack(cfg.cfg_ack), .func_reset(cfg.func_reset));
  initial begin
    forever #20 clk_i = ~clk_i;
  end
  task automatic chk(input logic [31:0] e, g, m);
    if (m != 0) begin
      comparisons++;
      if ((g & m) !== (e & m)) begin
        failures++;
        $display("mismatch at %0t: got %h expected %h", $time, g, e);
      end
    end
  endtask : chk
  // read data and lookup results are judged here, in order of issue
  always @(posedge clk_i) begin
    if (rd_dp && hready === 1'b1) chk(rq.pop_front(), hrdata, rm.pop_front());
    if (rd_dp && hready === 1'b1) chk(32'h0, {31'h0, hresp}, 32'h1);
    if (lk_done === 1'b1) chk({26'h0, lq.pop_front()}, {lk_hit, lk_to_port, lk_port}, 32'h3f);
    rd_dp <= htrans[1] && hsel && !hwrite && hready === 1'b1;
  end
  task automatic ahb(input logic w, input logic [4:0] a, input logic [31:0] d, m,
                     output logic [31:0] q);
    @(posedge clk_i);
    htrans <= 2'h2;
    hsel   <= 1'b1;
    hsize  <= 3'h2;
    haddr  <= {27'h0, a};
    hwrite <= w;
    if (!w) rq.push_back(d);
    if (!w) rm.push_back(m);
    @(posedge clk_i);
    while (hready !== 1'b1) @(posedge clk_i);
    htrans <= 2'h0;
    hsel   <= 1'b0;
    hwdata <= w ? d : ~hwdata;
    @(posedge clk_i);
    while (hready !== 1'b1) @(posedge clk_i);
    q = hrdata;
  endtask : ahb
  task automatic ecmd(input logic [3:0] off, input logic w, nm, input logic [31:0] d);
    logic [31:0] q;
    int          n;
    if (w) ahb(1'b1, CTL_WDATA, d, 0, q);
    ahb(1'b1, CTL_CMD, {22'h0, nm, 1'b0, off, 2'h0, w, 1'b1}, 0, q);
    n = 0;
    do begin
      ahb(1'b0, CTL_STATUS, 0, 0, q);
      n++;
    end while (q[ST_BUSY] !== 1'b0 && n < 50);
    if (q[ST_BUSY] !== 1'b0) begin
      failures++;
      $display("mismatch at %0t: entry command never finished", $time);
    end
  endtask : ecmd
  task automatic erd(input logic [3:0] off, input logic [31:0] e);
    logic [31:0] q;
    ecmd(off, 1'b0, 1'b0, 0);
    ahb(1'b0, CTL_RDATA, e, '1, q);
  endtask : erd
  task automatic look(input logic [31:0] a);
    logic [31:0] x;
    logic [3:0]  m;
    x = a & e_hash;
    m = 4'h0;
    for (int i = 0; i < 8; i++) m = m ^ x[4*i +: 4];
    @(posedge clk_i);
    lk_req  <= 1'b1;
    lk_addr <= {$urandom, a};
    if (!(e_attr[0] && a >= e_st && a <= e_end)) lq.push_back(6'h0);
    else if (!e_attr[1]) lq.push_back(6'h20);
    else lq.push_back({2'h3, e_attr[7:4] + (m & e_attr[13:10])});
    @(posedge clk_i);
    lk_req <= 1'b0;
  endtask : look
  task automatic final_report();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : final_report
  initial begin
    #800000;
    failures++;
    final_report();
  end
  initial begin
    logic [31:0] q, a, r;
    q = $urandom(64376);
    e_attr = '0;
    e_st = '0;
    e_end = '0;
    e_hash = '0;
    repeat (2) @(posedge clk_i);
    srst_i <= 1'b0;
    erd(OFF_ATTR, 0);
    erd(4'h2, 0);
    ahb(1'b0, 5'h10, 0, '1, q);
    look($urandom);
    // one entry alone cannot overlap another window
    // every count encoding; only the legal ones may land
    for (int k = 0; k < 16; k++) begin
      e_st  = $urandom & 32'h7fff_ffff;
      e_end = e_st + ($urandom & 32'hf_ffff);
      a     = $urandom;
      ecmd(OFF_START, 1'b1, 1'b0, e_st);
      ecmd(OFF_END, 1'b1, 1'b0, e_end);
      ecmd(OFF_HASH, 1'b1, 1'b0, a);
      e_hash = a & HASH_WR_MASK;
      erd(OFF_HASH, e_hash);
      erd(OFF_END, e_end);
      a = $urandom;
      a[13:10] = k[3:0];
      a[1:0] = 2'h3;
      ecmd(OFF_ATTR, 1'b1, 1'b1, a);
      q = {30'h0, !(a[13:10] inside {4'h0, 4'h1, 4'h3, 4'h7, 4'hf}), 1'b0};
      ahb(1'b0, CTL_STATUS, q, 32'h2, r);
      if (q == 0) e_attr = a & ATTR_WR_MASK;
      erd(OFF_ATTR, e_attr);
      look(e_st);
      look(e_end);
      look(e_end + 1);
      for (int j = 0; j < 4; j++) look(e_st + $urandom % (e_end - e_st + 1));
    end
    ecmd(OFF_ATTR, 1'b1, 1'b1, 32'h0000_0401);
    ahb(1'b0, CTL_STATUS, 32'h2, 32'h2, q);
    ecmd(OFF_ATTR, 1'b1, 1'b0, 32'h0000_0403);
    ahb(1'b0, CTL_STATUS, 32'h2, 32'h2, q);
    erd(OFF_ATTR, e_attr);
    e_attr = 32'h1;
    ecmd(OFF_ATTR, 1'b1, 1'b1, e_attr);
    look(e_end);
    e_attr = 32'h1c13;
    ecmd(OFF_ATTR, 1'b1, 1'b1, e_attr);
    ahb(1'b1, CTL_CMD, 32'h100, 0, q);
    e_attr = e_attr & AGG_FIELD_MASK;
    e_st = '0;
    e_end = '0;
    e_hash = '0;
    erd(OFF_ATTR, e_attr);
    erd(OFF_START, 0);
    look(0);
    srst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    srst_i <= 1'b0;
    erd(OFF_ATTR, 0);
    repeat (2) @(posedge clk_i);
    final_report();
  end
endmodule : tb
